// ---- bench/sfae_host_model.sv ----
// Host side model: loads the bank byte and sends commands with address bytes
`timescale 1ns/100ps
module sfae_host_model
    import sfae_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Toward the block
    output logic bank_wr,
    output logic [BANK_W-1:0] bank_wdata,
    output logic cmd_start,
    output sfae_cmd_t cmd,
    output logic abyte_vld,
    output logic [7:0] abyte
);
    logic ext = 1'b0;
    initial {bank_wr, bank_wdata, cmd_start, cmd, abyte_vld, abyte} = '0;
    always @(negedge arst_n) ext = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    task automatic wr_bank(input logic [7:0] v);
        @(posedge clk_sys);
        {cmd_start, abyte_vld} <= 2'h0;
        bank_wr <= 1'b1;
        bank_wdata <= v;
        ext = v[EXT_MODE_BIT];
        @(posedge clk_sys);
        bank_wr <= 1'b0;
        bank_wdata <= ~v;
    endtask : wr_bank
    // Leaves the last byte up so the next command may follow at once
    task automatic send(input sfae_cmd_t c, input logic [31:0] a);
        int n;
        n = (!c.legacy || c.space != SFAE_SP_ARRAY || ext) ? 4 : 3;
        @(posedge clk_sys);
        abyte_vld <= 1'b0;
        cmd_start <= 1'b1;
        cmd <= c;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk_sys);
            cmd_start <= 1'b0;
            cmd <= ~c;
            abyte_vld <= 1'b1;
            abyte <= a[8*i+:8];
        end
    endtask : send
    task automatic idle();
        @(posedge clk_sys);
        abyte_vld <= 1'b0;
        abyte <= ~abyte;
        @(posedge clk_sys);
    endtask : idle
endmodule : sfae_host_model

// ---- bench/test_serial_flash_address_extension.sv ----
// Self-checking bench for the address extension block
`timescale 1ns/100ps
module test_serial_flash_address_extension;
    import sfae_pkg::*;
    typedef struct packed {logic [1:0] idx; sfae_acc_t acc;} sfae_note_t;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic bank_wr, cmd_start, abyte_vld, ext_mode, acc_vld;
    logic [7:0] bank_wdata, abyte, bank_q, bk;
    logic [1:0] addr_last_idx;
    sfae_cmd_t cmd;
    sfae_acc_t acc, acc_sm;
    sfae_note_t notes[$];
    sfae_cmd_t cl[4] = '{{1'b1, SFAE_SP_ARRAY}, {1'b0, SFAE_SP_ARRAY},
                         {1'b1, SFAE_SP_OTP}, {1'b0, SFAE_SP_IDCFI}};
    int errors = 0;
    int check_count = 0;
    always #2.5 clk_sys = ~clk_sys;
    sfae_host_model i_sfae_host_model (.clk_sys(clk_sys), .arst_n(arst_n), .bank_wr(bank_wr),
        .bank_wdata(bank_wdata), .cmd_start(cmd_start), .cmd(cmd), .abyte_vld(abyte_vld),
        .abyte(abyte));
    sfae_addr_ext i_sfae_addr_ext (.clk_sys(clk_sys), .arst_n(arst_n), .bank_wr(bank_wr),
        .bank_wdata(bank_wdata), .cmd_start(cmd_start), .cmd(cmd), .abyte_vld(abyte_vld),
        .abyte(abyte), .addr_last_idx(addr_last_idx), .bank_q(bank_q), .ext_mode(ext_mode),
        .acc_vld(acc_vld), .acc(acc));
    // Small density copy sees the same traffic
    sfae_addr_ext #(.SMALL_DENSITY(1'b1)) i_sfae_addr_ext_small (.clk_sys(clk_sys),
        .arst_n(arst_n), .bank_wr(bank_wr), .bank_wdata(bank_wdata), .cmd_start(cmd_start),
        .cmd(cmd), .abyte_vld(abyte_vld), .abyte(abyte), .addr_last_idx(), .bank_q(),
        .ext_mode(), .acc_vld(), .acc(acc_sm));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_note(input sfae_note_t got, input sfae_note_t exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_note
    task automatic cmp_reg(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic close_out();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // Expectation worked out from the bank copy kept here
    task automatic run(input sfae_cmd_t c, input logic [31:0] a);
        logic n4;
        n4 = !c.legacy || c.space != SFAE_SP_ARRAY || bk[EXT_MODE_BIT];
        notes.push_back({n4 ? BYTES_EXT : BYTES_LEG, n4 ? a : {bk, a[23:0]}, c.space});
        i_sfae_host_model.send(c, a);
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin : mon
        sfae_note_t n;
        if (acc_vld === 1'b1)
        begin
            n = notes.pop_front();
            cmp_note({addr_last_idx, acc}, n);
            if (n.acc.space == SFAE_SP_ARRAY)
                n.acc.addr[31:24] = 8'h00;
            cmp_note({addr_last_idx, acc_sm}, n);
        end
    end
    initial
    begin
        #20000;
        errors++;
        close_out();
    end
    initial
    begin
        void'($urandom(4));
        for (int r = 0; r < 2; r++)
        begin
            bk = 8'h00;
            repeat (16) @(posedge clk_sys);
            arst_n <= 1'b1;
            @(negedge clk_sys);
            cmp_reg({ext_mode, bank_q}, 9'h000);
            run(cl[0], $urandom());
            for (int i = 0; i < 4; i++)
            begin
                bk = 8'($urandom()) & 8'h7F | (i[0] ? 8'h80 : 8'h00);
                i_sfae_host_model.wr_bank(bk);
                @(negedge clk_sys);
                cmp_reg({ext_mode, bank_q}, {bk[7], bk});
                foreach (cl[k])
                    run(cl[k], $urandom());
            end
            i_sfae_host_model.idle();
            @(posedge clk_sys);
            arst_n <= 1'b0;
        end
        if (notes.size() != 0)
            errors++;
        close_out();
    end
endmodule : test_serial_flash_address_extension

// ---- shared/sfae_pkg.sv ----
// Package for the serial flash address extension block
package sfae_pkg;

    localparam int ADDR_W = 32;
    localparam int LEG_ADDR_W = 24;
    localparam int BANK_W = 8;
    localparam int BANK_LSB = 0;
    localparam int EXT_MODE_BIT = 7;
    localparam logic [BANK_W-1:0] BANK_RST = 8'h00;
    localparam logic [1:0] BYTES_LEG = 2'h2;
    localparam logic [1:0] BYTES_EXT = 2'h3;

    typedef enum logic [1:0]
    {
        SFAE_SP_ARRAY = 2'b00,
        SFAE_SP_OTP = 2'b01,
        SFAE_SP_IDCFI = 2'b10
    } sfae_space_t;

    // One command as seen by this block, decoded upstream
    typedef struct packed {
        logic legacy;
        sfae_space_t space;
    } sfae_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        sfae_space_t space;
    } sfae_acc_t;

endpackage : sfae_pkg

// ---- verilog/sfae_addr_ext.sv ----
// Address extension: bank register, address width choice and assembly
//
// Operation
// [RULE1] Accept 32-bit byte addresses, up to 4 GB
// [RULE2] Legacy commands still accept 24-bit addresses
// [RULE3] Command-loaded bank register supplies upper bits
// [RULE4] Extended mode bit: legacy commands take 32 bits
// [RULE5] Newer commands always take 32-bit addresses
// [RULE6] Reset clears bank register, selects 24-bit mode
// [RULE7] Small density ignores address bits 31..24; the code clears them for the array space only, OTP and ID-CFI keep them
// [RULE8] Separate spaces also take full 32-bit address
// [RULE9] 24-bit mode: bank value fills bits 31..24
`timescale 1ns/100ps
module sfae_addr_ext
    import sfae_pkg::*;
#(
    parameter bit SMALL_DENSITY = 1'b0
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Bank register load from command decoder
    input wire logic bank_wr,
    input wire logic [BANK_W-1:0] bank_wdata,
    // Command start, tells how many address bytes to gather
    input wire logic cmd_start,
    input wire sfae_cmd_t cmd,
    // Address byte stream, most significant byte first
    input wire logic abyte_vld,
    input wire logic [7:0] abyte,
    // Results
    output logic [1:0] addr_last_idx,
    output logic [BANK_W-1:0] bank_q,
    output logic ext_mode,
    output logic acc_vld,
    output sfae_acc_t acc
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_ADDR = 1'b1
    } st_t;

    logic [BANK_W-1:0] bank_ff, nxt_bank;
    st_t st_ff, nxt_st;
    logic [1:0] idx_ff, nxt_idx;
    logic [1:0] last_ff, nxt_last;
    logic [ADDR_W-1:0] sh_ff, nxt_sh;
    sfae_space_t sp_ff, nxt_sp;
    logic vld_ff, nxt_vld;
    sfae_acc_t acc_ff, nxt_acc;
    logic [ADDR_W-1:0] full_addr;

    ////////////////////////////////////////////////////////////////////////
    // Bank register
    always_comb
    begin
        nxt_bank = bank_ff;
        if (bank_wr)
            nxt_bank = bank_wdata; // RULE3
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            bank_ff <= BANK_RST; // RULE6
        else
            bank_ff <= nxt_bank;
    end

    assign bank_q = bank_ff;
    assign ext_mode = bank_ff[EXT_MODE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Address gathering
    always_comb
    begin
        nxt_st = st_ff;
        nxt_idx = idx_ff;
        nxt_last = last_ff;
        nxt_sh = sh_ff;
        nxt_sp = sp_ff;
        nxt_vld = 1'b0;
        nxt_acc = acc_ff;
        full_addr = sh_ff;
        unique case (st_ff)
            ST_IDLE:
            begin
                if (cmd_start)
                begin
                    nxt_st = ST_ADDR;
                    nxt_idx = 2'h0;
                    nxt_sh = '0;
                    nxt_sp = cmd.space;
                    // Mode is sampled at command start, so a later bank write cannot
                    // change the byte count; a 24-bit address takes bank_ff at its last byte
                    if (!cmd.legacy || cmd.space != SFAE_SP_ARRAY)
                        nxt_last = BYTES_EXT; // RULE5 RULE8
                    else if (bank_ff[EXT_MODE_BIT])
                        nxt_last = BYTES_EXT; // RULE4
                    else
                        nxt_last = BYTES_LEG; // RULE2
                end
            end
            ST_ADDR:
            begin
                if (abyte_vld)
                begin
                    nxt_sh = {sh_ff[ADDR_W-9:0], abyte}; // RULE1
                    nxt_idx = 2'(idx_ff + 2'h1);
                    if (idx_ff == last_ff)
                    begin
                        full_addr = nxt_sh;
                        if (last_ff == BYTES_LEG)
                            full_addr = {bank_ff, nxt_sh[LEG_ADDR_W-1:0]}; // RULE9
                        if (SMALL_DENSITY && sp_ff == SFAE_SP_ARRAY)
                            full_addr[ADDR_W-1:LEG_ADDR_W] = '0; // RULE7
                        nxt_acc.addr = full_addr;
                        nxt_acc.space = sp_ff;
                        nxt_vld = 1'b1;
                        nxt_st = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= ST_IDLE;
            idx_ff <= 2'h0;
            last_ff <= BYTES_LEG;
            sh_ff <= '0;
            sp_ff <= SFAE_SP_ARRAY;
            vld_ff <= 1'b0;
            acc_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;
            last_ff <= nxt_last;
            sh_ff <= nxt_sh;
            sp_ff <= nxt_sp;
            vld_ff <= nxt_vld;
            acc_ff <= nxt_acc;
        end
    end

    assign addr_last_idx = last_ff;
    assign acc_vld = vld_ff;
    assign acc = acc_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_legacy_start;
        cmd_start && st_ff == ST_IDLE && cmd.legacy && cmd.space == SFAE_SP_ARRAY;
    endsequence

    AST_BANK_LOAD: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE3
        bank_wr |=> bank_q == $past(bank_wdata))
        else $error("bank register did not load");
    AST_LEG24: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
        (s_legacy_start and !ext_mode) |=> addr_last_idx == BYTES_LEG)
        else $error("legacy command not in 24-bit mode");
    AST_LEG32: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE4
        (s_legacy_start and ext_mode) |=> addr_last_idx == BYTES_EXT)
        else $error("extended mode did not give 32-bit address");
    AST_NEW32: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE5
        cmd_start && st_ff == ST_IDLE && !cmd.legacy |=> addr_last_idx == BYTES_EXT)
        else $error("newer command not 32-bit");
    AST_SPACE32: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE8
        cmd_start && st_ff == ST_IDLE && cmd.space != SFAE_SP_ARRAY
        |=> addr_last_idx == BYTES_EXT)
        else $error("separate space not 32-bit");
    AST_UPPER_BANK: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE9
        st_ff == ST_ADDR && abyte_vld && idx_ff == last_ff && last_ff == BYTES_LEG
        && !SMALL_DENSITY && !bank_wr |=> acc_vld && acc.addr[31:24] == bank_q)
        else $error("upper bits not from bank register");
    AST_SMALL: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE7
        acc_vld && SMALL_DENSITY && acc.space == SFAE_SP_ARRAY |-> acc.addr[31:24] == 8'h00)
        else $error("small density kept upper byte");
    AST_FULL32: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
        st_ff == ST_ADDR && abyte_vld && idx_ff == BYTES_EXT && last_ff == BYTES_EXT
        && (!SMALL_DENSITY || sp_ff != SFAE_SP_ARRAY)
        |=> acc_vld && acc.addr == {$past(sh_ff[23:0]), $past(abyte)})
        else $error("32-bit address wrong");
    AST_RESET: assert property (@(posedge clk_sys) // RULE6
        $rose(arst_n) |-> bank_q == BANK_RST && !ext_mode)
        else $error("bank not cleared at reset");

    // Whole-command steps; only back-to-back bytes, a gap just delays the result
    sequence s_leg24_start;
        s_legacy_start and !ext_mode;
    endsequence

    sequence s_addr32_start;
        cmd_start && st_ff == ST_IDLE
        && (!cmd.legacy || cmd.space != SFAE_SP_ARRAY || ext_mode);
    endsequence

    sequence s_three_bytes;
        abyte_vld [*3];
    endsequence

    AST_LEG24_DONE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
        s_leg24_start ##1 s_three_bytes |=> acc_vld)
        else $error("legacy address not done after three bytes");
    AST_EXT_WAIT: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
        s_addr32_start ##1 s_three_bytes |=> !acc_vld)
        else $error("32-bit address ended after three bytes");
    AST_EXT_DONE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
        s_addr32_start ##1 s_three_bytes ##1 abyte_vld |=> acc_vld)
        else $error("32-bit address not done after four bytes");
    AST_ONE_PULSE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
        acc_vld |=> !acc_vld)
        else $error("result valid longer than one cycle");

endmodule : sfae_addr_ext
